// [logic/dacscp_defs.vh]
`ifndef DACSCP_DEFS_VH
`define DACSCP_DEFS_VH

// ----------------------------------------------------------------------------
// Register addresses (5-bit serial address space)
// ----------------------------------------------------------------------------
`define DACSCP_ADDR_DLL_TIMING      5'h0a
`define DACSCP_ADDR_PLL_VCO         5'h0b
`define DACSCP_ADDR_OFFSET_UPPER    5'h0c
`define DACSCP_ADDR_OFFSET_LOWER    5'h0d
`define DACSCP_ADDR_STATUS_SELECT   5'h0e
`define DACSCP_ADDR_SPARE           5'h0f

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DACSCP_RST_DLL_TIMING       8'h00
`define DACSCP_RST_PLL_VCO          8'h00
`define DACSCP_RST_OFFSET_UPPER     8'h00
`define DACSCP_RST_OFFSET_LOWER     8'h00
`define DACSCP_RST_STATUS_SELECT    8'h00
`define DACSCP_RST_SPARE            8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DACSCP_DLL_DELAY_MSB        7
`define DACSCP_DLL_DELAY_LSB        4
`define DACSCP_DLL_INVCLK_BIT       3
`define DACSCP_DLL_BIAS_MSB         2
`define DACSCP_DLL_BIAS_LSB         0
`define DACSCP_LPF_CLEAR_BIT        7
`define DACSCP_VCO_HALVE_BIT        6
`define DACSCP_VCO_GAIN_MSB         5
`define DACSCP_VCO_GAIN_LSB         4
`define DACSCP_VCO_RANGE_MSB        3
`define DACSCP_VCO_RANGE_LSB        0
`define DACSCP_OFFSET_SYNC_BIT      5
`define DACSCP_OFFSET_HIGH_MSB      4
`define DACSCP_STATUS_SEL_MSB       7
`define DACSCP_STATUS_SEL_LSB       5
`define DACSCP_INSTR_READ_BIT       7
`define DACSCP_INSTR_COUNT_MSB      6
`define DACSCP_INSTR_COUNT_LSB      5
`define DACSCP_INSTR_ADDR_MSB       4

// ----------------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------------
`define DACSCP_DELAY_NOMINAL_DEG    7'h5a
`define DACSCP_DELAY_STEP_DEG       7'h05
`define DACSCP_DLL_BIAS_FORBIDDEN   3'h4
`define DACSCP_SEL_PLL_LOCK         3'h1
`define DACSCP_SEL_DLL_LOCK         3'h2
`define DACSCP_SEL_PATTERN_ERR      3'h3
`define DACSCP_SEL_FIFO_ERR         3'h4
`define DACSCP_SEL_SELFTEST_FAIL    3'h5

`endif

// [logic/dacscp_top.v]
// Behaviour
// - Delay trim code is signed around 90 degrees, 5 degrees per step, 50 to 125.
// - Invert bit set inverts the internal delay-loop clock.
// - Three-bit bias field selects delay-line bias; code 100 must never be used; logic only flags it and still passes it through.
// - Loop filter held at 0V while clear bit high; host toggles 1 then 0.
// - Halve bit set divides oscillator output by two.
// - Two-bit gain field sets oscillator gain; higher code, wider range.
// - Four-bit range field sets oscillator bias: 0000 lowest, 1111 highest.
// - Zero-to-one of update bit copies staged offsets to working offsets.
// - Update bit stays as written; never cleared by hardware.
// - Path A staged offset: bits 12:8 in 0x0C low bits, 7:0 in 0x0D.
// - Selector routes status pin: lock, error or normal serial output.
// - In four-wire mode a selected status overrides serial read data.
// - Three-wire with shared data pin, or four-wire with separate out pin.
// - Serial input bits are sampled on serial clock rising edges.
// - Frame enable low for two to five bytes: instruction then data.
// - Instruction bit 7 read/write, bits 6:5 count, bits 4:0 address.
// - Data byte count is code plus one; bytes sent MSB first.
// - Address starts at instruction address and decrements per later byte.
// - Three-wire read drives shared pin, keeps dedicated out pin released unless a status is selected.
// - Four-wire read drives out pin low from last falling edge to frame end.
`timescale 1ns/100ps
`include "dacscp_defs.vh"

module dacscp_top (
    input  wire        CLK_I,
    input  wire        RESET_I,
    input  wire        SERIAL_CLOCK_I,
    input  wire        FRAME_ENABLE_N_I,
    input  wire        SERIAL_DATA_IO_I,
    output reg         SERIAL_DATA_IO_O,
    output reg         SERIAL_DATA_IO_OE_O,
    output reg         SERIAL_DATA_OUT_O,
    output reg         SERIAL_DATA_OUT_OE_O,
    input  wire        FOUR_WIRE_SELECT_I,
    input  wire        PLL_LOCK_I,
    input  wire        DLL_LOCK_I,
    input  wire        PATTERN_ERR_I,
    input  wire        FIFO_ERR_I,
    input  wire        SELFTEST_FAIL_I,
    input  wire [12:0] PATH_B_STAGED_I,
    output reg  [6:0]  DLL_DELAY_DEG_O,
    output reg         DLL_CLK_INVERT_O,
    output reg  [2:0]  DLL_BIAS_SEL_O,
    output reg         DLL_BIAS_FORBIDDEN_O,
    output reg         LOOP_FILTER_CLEAR_O,
    output reg         OSCILLATOR_HALVE_O,
    output reg  [1:0]  VCO_GAIN_O,
    output reg  [3:0]  VCO_RANGE_O,
    output reg  [12:0] PATH_A_OFFSET_O,
    output reg  [12:0] PATH_B_OFFSET_O
);

    // ------------------------------------------------------------------------
    // Frame phases
    // ------------------------------------------------------------------------
    localparam [1:0] PH_INSTR = 2'b00;
    localparam [1:0] PH_DATA  = 2'b01;
    localparam [1:0] PH_DONE  = 2'b10;

    // ------------------------------------------------------------------------
    // Delay trim decode
    // ------------------------------------------------------------------------
    // Signed code, wraps mod 128 so negative steps land on 50..85
    function [6:0] dacscp_delay_deg;
        input [3:0] code;
        begin
            dacscp_delay_deg = `DACSCP_DELAY_NOMINAL_DEG
                             + ({{3{code[3]}}, code} * `DACSCP_DELAY_STEP_DEG);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    reg        sclk_s1_reg;
    reg        sclk_s2_reg;
    reg        sclk_s3_reg;
    reg        sclk_f_reg;
    reg        en_s1_reg;
    reg        en_s2_reg;
    reg        en_s3_reg;
    reg        en_f_reg;
    reg        din_s1_reg;
    reg        din_s2_reg;
    reg        din_s3_reg;

    always @(posedge CLK_I) begin
        if (RESET_I) begin
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
            sclk_f_reg  <= 1'b0;
            en_s1_reg   <= 1'b1;
            en_s2_reg   <= 1'b1;
            en_s3_reg   <= 1'b1;
            en_f_reg    <= 1'b1;
            din_s1_reg  <= 1'b0;
            din_s2_reg  <= 1'b0;
            din_s3_reg  <= 1'b0;
        end else begin
            sclk_s1_reg <= SERIAL_CLOCK_I;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            en_s1_reg   <= FRAME_ENABLE_N_I;
            en_s2_reg   <= en_s1_reg;
            en_s3_reg   <= en_s2_reg;
            din_s1_reg  <= SERIAL_DATA_IO_I;
            din_s2_reg  <= din_s1_reg;
            din_s3_reg  <= din_s2_reg;
            if (sclk_s2_reg == sclk_s3_reg) begin
                sclk_f_reg <= sclk_s3_reg;
            end
            if (en_s2_reg == en_s3_reg) begin
                en_f_reg <= en_s3_reg;
            end
        end
    end

    // A change counts only once stages two and three agree
    wire sclk_rise = (sclk_s2_reg == sclk_s3_reg) && sclk_s3_reg && !sclk_f_reg;
    wire sclk_fall = (sclk_s2_reg == sclk_s3_reg) && !sclk_s3_reg && sclk_f_reg;
    wire frame_on  = !en_f_reg;

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    reg  [7:0]  dll_timing_ctrl_reg;
    reg  [7:0]  pll_vco_ctrl_reg;
    reg  [7:0]  offset_update_upper_reg;
    reg  [7:0]  offset_lower_reg;
    reg  [7:0]  status_pin_select_reg;

    // ------------------------------------------------------------------------
    // Serial engine state
    // ------------------------------------------------------------------------
    reg  [1:0]  phase_reg;
    reg  [2:0]  bit_cnt_reg;
    reg  [6:0]  shift_reg;
    reg         is_read_reg;
    reg  [1:0]  bytes_left_reg;
    reg  [4:0]  addr_reg;
    reg         tx_on_reg;
    reg         tx_bit_reg;
    reg  [12:0] path_a_work_reg;
    reg  [12:0] path_b_work_reg;

    wire [7:0] rx_byte = {shift_reg, din_s3_reg};

    // ------------------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------------------
    reg  [7:0] rd_data;

    always @* begin
        case (addr_reg)
            `DACSCP_ADDR_DLL_TIMING:    rd_data = dll_timing_ctrl_reg;
            `DACSCP_ADDR_PLL_VCO:       rd_data = pll_vco_ctrl_reg;
            `DACSCP_ADDR_OFFSET_UPPER:  rd_data = offset_update_upper_reg;
            `DACSCP_ADDR_OFFSET_LOWER:  rd_data = offset_lower_reg;
            `DACSCP_ADDR_STATUS_SELECT: rd_data = status_pin_select_reg;
            `DACSCP_ADDR_SPARE:         rd_data = `DACSCP_RST_SPARE;
            default:                    rd_data = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // Frame sequencing, register writes, read launch
    // ------------------------------------------------------------------------
    always @(posedge CLK_I) begin
        if (RESET_I) begin
            phase_reg               <= PH_INSTR;
            bit_cnt_reg             <= 3'h0;
            shift_reg               <= 7'h00;
            is_read_reg             <= 1'b0;
            bytes_left_reg          <= 2'h0;
            addr_reg                <= 5'h00;
            tx_on_reg               <= 1'b0;
            tx_bit_reg              <= 1'b0;
            dll_timing_ctrl_reg     <= `DACSCP_RST_DLL_TIMING;
            pll_vco_ctrl_reg        <= `DACSCP_RST_PLL_VCO;
            offset_update_upper_reg <= `DACSCP_RST_OFFSET_UPPER;
            offset_lower_reg        <= `DACSCP_RST_OFFSET_LOWER;
            status_pin_select_reg   <= `DACSCP_RST_STATUS_SELECT;
            path_a_work_reg         <= 13'h0000;
            path_b_work_reg         <= 13'h0000;
        end else if (!frame_on) begin
            // Any partial byte is simply dropped here
            phase_reg   <= PH_INSTR;
            bit_cnt_reg <= 3'h0;
            tx_on_reg   <= 1'b0;
            tx_bit_reg  <= 1'b0;
        end else begin
            if (sclk_rise && phase_reg != PH_DONE) begin
                shift_reg   <= rx_byte[6:0];
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    if (phase_reg == PH_INSTR) begin
                        is_read_reg    <= rx_byte[`DACSCP_INSTR_READ_BIT];
                        bytes_left_reg <= rx_byte[`DACSCP_INSTR_COUNT_MSB:
                                                  `DACSCP_INSTR_COUNT_LSB];
                        addr_reg       <= rx_byte[`DACSCP_INSTR_ADDR_MSB:0];
                        phase_reg      <= PH_DATA;
                    end else begin
                        if (!is_read_reg) begin
                            case (addr_reg)
                                `DACSCP_ADDR_DLL_TIMING: begin
                                    dll_timing_ctrl_reg <= rx_byte;
                                end
                                `DACSCP_ADDR_PLL_VCO: begin
                                    pll_vco_ctrl_reg <= rx_byte;
                                end
                                `DACSCP_ADDR_OFFSET_UPPER: begin
                                    // Update bit kept as written, reserved bits dropped
                                    offset_update_upper_reg <= {2'b00, rx_byte[5:0]};
                                    if (!offset_update_upper_reg[`DACSCP_OFFSET_SYNC_BIT]
                                        && rx_byte[`DACSCP_OFFSET_SYNC_BIT]) begin
                                        // Staged upper bits come from this very write
                                        path_a_work_reg <= {rx_byte[`DACSCP_OFFSET_HIGH_MSB:0],
                                                            offset_lower_reg};
                                        path_b_work_reg <= PATH_B_STAGED_I;
                                    end
                                end
                                `DACSCP_ADDR_OFFSET_LOWER: begin
                                    offset_lower_reg <= rx_byte;
                                end
                                `DACSCP_ADDR_STATUS_SELECT: begin
                                    status_pin_select_reg <= {rx_byte[7:5], 5'h00};
                                end
                                default: begin
                                    // Spare and out-of-block addresses ignore writes
                                end
                            endcase
                        end
                        if (bytes_left_reg == 2'h0) begin
                            phase_reg <= PH_DONE;
                        end else begin
                            bytes_left_reg <= bytes_left_reg - 2'h1;
                            addr_reg       <= addr_reg - 5'h01;
                        end
                    end
                end
            end
            if (sclk_fall && is_read_reg) begin
                if (phase_reg == PH_DATA) begin
                    tx_on_reg  <= 1'b1;
                    tx_bit_reg <= rd_data[3'h7 - bit_cnt_reg];
                end else if (phase_reg == PH_DONE) begin
                    // Four-wire holds low until frame end, three-wire lets go
                    tx_on_reg  <= FOUR_WIRE_SELECT_I;
                    tx_bit_reg <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers and status routing
    // ------------------------------------------------------------------------
    reg [2:0] sel;
    reg       status_pick;
    reg       status_val;

    always @* begin
        sel         = status_pin_select_reg[`DACSCP_STATUS_SEL_MSB:`DACSCP_STATUS_SEL_LSB];
        status_pick = 1'b1;
        case (sel)
            `DACSCP_SEL_PLL_LOCK:      status_val = PLL_LOCK_I;
            `DACSCP_SEL_DLL_LOCK:      status_val = DLL_LOCK_I;
            `DACSCP_SEL_PATTERN_ERR:   status_val = PATTERN_ERR_I;
            `DACSCP_SEL_FIFO_ERR:      status_val = FIFO_ERR_I;
            `DACSCP_SEL_SELFTEST_FAIL: status_val = SELFTEST_FAIL_I;
            default: begin
                status_pick = 1'b0;
                status_val  = 1'b0;
            end
        endcase
    end

    always @(posedge CLK_I) begin
        if (RESET_I) begin
            SERIAL_DATA_IO_O     <= 1'b0;
            SERIAL_DATA_IO_OE_O  <= 1'b0;
            SERIAL_DATA_OUT_O    <= 1'b0;
            SERIAL_DATA_OUT_OE_O <= 1'b0;
        end else begin
            // Three-wire: read data on the shared pin only
            SERIAL_DATA_IO_O    <= tx_bit_reg;
            SERIAL_DATA_IO_OE_O <= tx_on_reg && !FOUR_WIRE_SELECT_I;
            if (status_pick) begin
                SERIAL_DATA_OUT_O    <= status_val;
                SERIAL_DATA_OUT_OE_O <= 1'b1;
            end else begin
                SERIAL_DATA_OUT_O    <= tx_bit_reg;
                SERIAL_DATA_OUT_OE_O <= tx_on_reg && FOUR_WIRE_SELECT_I;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Decoded controls to the analog side
    // ------------------------------------------------------------------------
    always @(posedge CLK_I) begin
        if (RESET_I) begin
            DLL_DELAY_DEG_O      <= `DACSCP_DELAY_NOMINAL_DEG;
            DLL_CLK_INVERT_O     <= 1'b0;
            DLL_BIAS_SEL_O       <= 3'h0;
            DLL_BIAS_FORBIDDEN_O <= 1'b0;
            LOOP_FILTER_CLEAR_O  <= 1'b0;
            OSCILLATOR_HALVE_O   <= 1'b0;
            VCO_GAIN_O           <= 2'h0;
            VCO_RANGE_O          <= 4'h0;
            PATH_A_OFFSET_O      <= 13'h0000;
            PATH_B_OFFSET_O      <= 13'h0000;
        end else begin
            DLL_DELAY_DEG_O  <= dacscp_delay_deg(
                dll_timing_ctrl_reg[`DACSCP_DLL_DELAY_MSB:`DACSCP_DLL_DELAY_LSB]);
            DLL_CLK_INVERT_O <= dll_timing_ctrl_reg[`DACSCP_DLL_INVCLK_BIT];
            DLL_BIAS_SEL_O   <= dll_timing_ctrl_reg[`DACSCP_DLL_BIAS_MSB:
                                                    `DACSCP_DLL_BIAS_LSB];
            // Flagged only; the bias code is still passed through unchanged
            DLL_BIAS_FORBIDDEN_O <= (dll_timing_ctrl_reg[`DACSCP_DLL_BIAS_MSB:
                                     `DACSCP_DLL_BIAS_LSB] == `DACSCP_DLL_BIAS_FORBIDDEN);
            LOOP_FILTER_CLEAR_O <= pll_vco_ctrl_reg[`DACSCP_LPF_CLEAR_BIT];
            OSCILLATOR_HALVE_O  <= pll_vco_ctrl_reg[`DACSCP_VCO_HALVE_BIT];
            VCO_GAIN_O          <= pll_vco_ctrl_reg[`DACSCP_VCO_GAIN_MSB:
                                                    `DACSCP_VCO_GAIN_LSB];
            VCO_RANGE_O         <= pll_vco_ctrl_reg[`DACSCP_VCO_RANGE_MSB:
                                                    `DACSCP_VCO_RANGE_LSB];
            PATH_A_OFFSET_O     <= path_a_work_reg;
            PATH_B_OFFSET_O     <= path_b_work_reg;
        end
    end

endmodule // dacscp_top

// [sim/dacscp_top_assertions.sv]
`timescale 1ns/100ps
module dacscp_checker (
    input logic        CLK_I,
    input logic        RESET_I,
    input logic        SERIAL_CLOCK_I,
    input logic        FRAME_ENABLE_N_I,
    input logic        FOUR_WIRE_SELECT_I,
    input logic        SERIAL_DATA_IO_O,
    input logic        SERIAL_DATA_IO_OE_O,
    input logic [6:0]  DLL_DELAY_DEG_O,
    input logic        DLL_CLK_INVERT_O,
    input logic [2:0]  DLL_BIAS_SEL_O,
    input logic        DLL_BIAS_FORBIDDEN_O,
    input logic        LOOP_FILTER_CLEAR_O,
    input logic        OSCILLATOR_HALVE_O,
    input logic [1:0]  VCO_GAIN_O,
    input logic [3:0]  VCO_RANGE_O,
    input logic [12:0] PATH_A_OFFSET_O,
    input logic [12:0] PATH_B_OFFSET_O
);
    logic [44:0] cfg_bus;
    assign cfg_bus = {DLL_DELAY_DEG_O, DLL_CLK_INVERT_O, DLL_BIAS_SEL_O, LOOP_FILTER_CLEAR_O,
        OSCILLATOR_HALVE_O, VCO_GAIN_O, VCO_RANGE_O, PATH_A_OFFSET_O, PATH_B_OFFSET_O};
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    // ------------------------------------------------------------------------
    // Pin drive, frame and decoded-output checks
    // ------------------------------------------------------------------------
    sequence idle_run;
        FRAME_ENABLE_N_I [*8];
    endsequence
    sequence bit_launch;
        SERIAL_DATA_IO_OE_O && $changed(SERIAL_DATA_IO_O);
    endsequence
    io_oe_mode_a: assert property (
        SERIAL_DATA_IO_OE_O |-> !FOUR_WIRE_SELECT_I) else $error("shared pin driven in 4-wire");
    idle_release_a: assert property (
        idle_run |-> !SERIAL_DATA_IO_OE_O) else $error("shared pin still driven after frame");
    oe_in_frame_a: assert property (
        $rose(SERIAL_DATA_IO_OE_O) |-> !FRAME_ENABLE_N_I) else $error("drive outside frame");
    launch_falling_a: assert property (
        bit_launch |-> !SERIAL_CLOCK_I) else $error("read bit changed while clock high");
    cfg_in_frame_a: assert property (
        $changed(cfg_bus) |-> !FRAME_ENABLE_N_I) else $error("config changed outside frame");
    delay_range_a: assert property (
        DLL_DELAY_DEG_O >= 7'd50 && DLL_DELAY_DEG_O <= 7'd125) else $error("delay out of range");
    delay_step_a: assert property (
        DLL_DELAY_DEG_O % 7'd5 == 7'd0) else $error("delay not on a 5 degree step");
    bias_flag_a: assert property (
        DLL_BIAS_FORBIDDEN_O == (DLL_BIAS_SEL_O == 3'h4)) else $error("bias flag mismatch");
endmodule // dacscp_checker

bind dacscp_top dacscp_checker u_chk (.CLK_I(CLK_I), .RESET_I(RESET_I),
    .SERIAL_CLOCK_I(SERIAL_CLOCK_I), .FRAME_ENABLE_N_I(FRAME_ENABLE_N_I),
    .FOUR_WIRE_SELECT_I(FOUR_WIRE_SELECT_I), .SERIAL_DATA_IO_O(SERIAL_DATA_IO_O),
    .SERIAL_DATA_IO_OE_O(SERIAL_DATA_IO_OE_O), .DLL_DELAY_DEG_O(DLL_DELAY_DEG_O),
    .DLL_CLK_INVERT_O(DLL_CLK_INVERT_O), .DLL_BIAS_SEL_O(DLL_BIAS_SEL_O),
    .DLL_BIAS_FORBIDDEN_O(DLL_BIAS_FORBIDDEN_O), .LOOP_FILTER_CLEAR_O(LOOP_FILTER_CLEAR_O),
    .OSCILLATOR_HALVE_O(OSCILLATOR_HALVE_O), .VCO_GAIN_O(VCO_GAIN_O),
    .VCO_RANGE_O(VCO_RANGE_O), .PATH_A_OFFSET_O(PATH_A_OFFSET_O),
    .PATH_B_OFFSET_O(PATH_B_OFFSET_O));

// [sim/dacscp_host.sv]
`timescale 1ns/100ps
module dacscp_host (
    input  logic clk_i,
    input  logic sd_i,
    input  logic so_i,
    input  logic so_oe_i,
    output logic sclk_o,
    output logic fen_n_o,
    output logic sd_o
);
    logic hold = 1'b0;
    logic end_val;
    logic end_oe;
    initial begin
        sclk_o = 1'b0;
        fen_n_o = 1'b1;
        sd_o = 1'b0;
    end
    // Released data line shows a moving pattern, never the last bit
    always @(posedge clk_i) if (!hold) sd_o <= ~sd_o;
    task automatic xfer(input logic [7:0] ins, input logic [31:0] wr, input int nb,
                        input logic four, output logic [31:0] rd);
        logic [39:0] sh;
        sh = {ins, wr};
        rd = '0;
        fen_n_o = 1'b0;
        for (int i = 0; i < 8 + nb; i++) begin
            hold = !(ins[7] && i >= 8);
            if (hold) sd_o = sh[39 - i];
            repeat (6) @(posedge clk_i);
            #1;
            if (i >= 8) rd = {rd[30:0], four ? so_i : sd_i};
            sclk_o = 1'b1;
            repeat (6) @(posedge clk_i);
            #1 sclk_o = 1'b0;
        end
        repeat (6) @(posedge clk_i);
        #1;
        end_val = so_i;
        end_oe = so_oe_i;
        fen_n_o = 1'b1;
        hold = 1'b0;
        repeat (8) @(posedge clk_i);
        #1;
    endtask
endmodule // dacscp_host

// [sim/dacscp_top_tb.sv]
`timescale 1ns/100ps
module dacscp_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic four = 1'b1;
    logic [4:0] st = '0;
    logic [12:0] pb = '0;
    logic [31:0] r = 32'h947a;
    logic [31:0] rd;
    logic [7:0] v, lo, b0b;
    logic sclk, fen_n, h_sd, io_o, io_oe, so, so_oe, inv, clr, halve, forb;
    logic [6:0] deg;
    logic [2:0] bias;
    logic [1:0] gain;
    logic [3:0] range;
    logic [12:0] pa_o, pb_o;
    int n_fail = 0;
    int checks = 0;
    wire sd_pin = io_oe ? io_o : h_sd;
    always #4 clk = ~clk;
    dacscp_top DUT (.CLK_I(clk), .RESET_I(rst), .SERIAL_CLOCK_I(sclk), .FRAME_ENABLE_N_I(fen_n),
        .SERIAL_DATA_IO_I(sd_pin), .SERIAL_DATA_IO_O(io_o), .SERIAL_DATA_IO_OE_O(io_oe),
        .SERIAL_DATA_OUT_O(so), .SERIAL_DATA_OUT_OE_O(so_oe), .FOUR_WIRE_SELECT_I(four),
        .PLL_LOCK_I(st[0]), .DLL_LOCK_I(st[1]), .PATTERN_ERR_I(st[2]), .FIFO_ERR_I(st[3]),
        .SELFTEST_FAIL_I(st[4]), .PATH_B_STAGED_I(pb), .DLL_DELAY_DEG_O(deg),
        .DLL_CLK_INVERT_O(inv), .DLL_BIAS_SEL_O(bias), .DLL_BIAS_FORBIDDEN_O(forb),
        .LOOP_FILTER_CLEAR_O(clr), .OSCILLATOR_HALVE_O(halve), .VCO_GAIN_O(gain),
        .VCO_RANGE_O(range), .PATH_A_OFFSET_O(pa_o), .PATH_B_OFFSET_O(pb_o));
    dacscp_host u_host (.clk_i(clk), .sd_i(sd_pin), .so_i(so), .so_oe_i(so_oe), .sclk_o(sclk),
        .fen_n_o(fen_n), .sd_o(h_sd));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [6:0] exp_deg(input logic [3:0] c);
        return 7'(90 + 5 * $signed(c));
    endfunction
    task automatic rnd;
        repeat (8) r = lfsr(r);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        u_host.xfer({3'b000, a}, {d, 24'h0}, 8, four, rd);
    endtask
    task automatic rdb(input logic [4:0] a, input logic [7:0] e);
        u_host.xfer({3'b100, a}, 32'h0, 8, four, rd);
        cmp(rd, {24'h0, e});
    endtask
    task automatic give_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        cmp(deg, 7'h5a);
        for (int i = 0; i < 16; i++) begin
            rnd();
            v = {i[3:0], r[3], (i == 4) ? 3'h4 : r[2:0]};
            wr(5'h0a, v);
            cmp({deg, inv, bias}, {exp_deg(v[7:4]), v[3:0]});
            cmp(forb, v[2:0] == 3'h4);
            wr(5'h08, 8'h04);
            wr(5'h08, 8'h00);
            wr(5'h0b, r[15:8]);
            cmp({clr, halve, gain, range}, r[15:8]);
        end
        $display("test config_fields done");
        rnd();
        b0b = r[7:0];
        lo = r[15:8];
        u_host.xfer(8'h6e, {8'hdf, lo, 3'b110, r[20:16], b0b}, 32, four, rd);
        u_host.xfer(8'hee, 32'h0, 32, four, rd);
        cmp(rd, {8'hc0, lo, 3'b000, r[20:16], b0b});
        cmp({u_host.end_oe, u_host.end_val}, 2'b10);
        cmp(pa_o, 13'h0);
        $display("test burst done");
        rnd();
        pb = r[12:0];
        wr(5'h0c, {3'b001, r[20:16]});
        cmp({pa_o, pb_o}, {r[20:16], lo, r[12:0]});
        v = {3'b001, r[20:16]};
        rnd();
        pb = r[12:0];
        wr(5'h0d, r[31:24]);
        wr(5'h0c, {3'b001, r[20:16]});
        cmp(pa_o, {v[4:0], lo});
        rdb(5'h0c, {3'b001, r[20:16]});
        wr(5'h0c, 8'h00);
        wr(5'h0c, {3'b001, r[20:16]});
        cmp({pa_o, pb_o}, {r[20:16], r[31:24], pb});
        $display("test offset done");
        four = 1'b0;
        rdb(5'h0b, b0b);
        cmp(u_host.end_oe, 1'b0);
        four = 1'b1;
        wr(5'h0f, 8'hff);
        rdb(5'h0f, 8'h00);
        rdb(5'h15, 8'h00);
        u_host.xfer(8'h0b, {~b0b, 24'h0}, 4, four, rd);
        rdb(5'h0b, b0b);
        u_host.xfer(8'hcd, 32'h0, 24, four, rd);
        cmp(rd, {8'h00, r[31:24], 3'b001, r[20:16], b0b});
        u_host.xfer(8'hae, 32'h0, 16, four, rd);
        cmp(rd, {16'h0, 8'hc0, r[31:24]});
        $display("test refusals done");
        for (int s = 0; s < 8; s++) begin
            wr(5'h0e, {s[2:0], 5'h00});
            rnd();
            st = r[4:0];
            repeat (6) @(posedge clk);
            #1;
            cmp({so_oe, so}, (s > 0 && s < 6) ? {1'b1, st[s - 1]} : 2'b00);
            if (s == 3) begin
                u_host.xfer(8'h8b, 32'h0, 8, four, rd);
                cmp(rd, {24'h0, {8{st[2]}}});
            end
        end
        $display("test status done");
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        give_verdict();
    end
endmodule // dacscp_top_tb
